// File: rtl/pmcb_pkg.sv
package pmcb_pkg;
	localparam int WORD_W       = 16;
	localparam int BYTE_W       = 8;
	localparam int SERIAL_BYTES = 12;
	localparam int PIN_COUNT    = 6;

	// command codes
	localparam logic [7:0] CMD_RUN_CONTROL = 8'h01, CMD_ENABLE_SOURCE_CONFIG = 8'h02, CMD_CLEAR_FAULTS = 8'h03,
		CMD_STORE_DEFAULTS = 8'h11, CMD_RESTORE_DEFAULTS = 8'h12, CMD_OUTPUT_VOLTAGE_FORMAT = 8'h20,
		CMD_OUTPUT_VOLTAGE_SETPOINT = 8'h21, CMD_OUTPUT_VOLTAGE_TRIM_OFFSET = 8'h23, CMD_MARGIN_HIGH_SETPOINT = 8'h25,
		CMD_MARGIN_LOW_SETPOINT = 8'h26, CMD_LOAD_DROOP_SLOPE = 8'h28, CMD_INPUT_TURN_ON_LEVEL = 8'h35,
		CMD_INPUT_TURN_OFF_LEVEL = 8'h36, CMD_OUTPUT_OVERVOLTAGE_LIMIT = 8'h40, CMD_OUTPUT_OVERVOLTAGE_ACTION = 8'h41,
		CMD_OVERCURRENT_LIMIT = 8'h46, CMD_OVERCURRENT_ACTION = 8'h47, CMD_OVERCURRENT_WARNING_LEVEL = 8'h4A,
		CMD_OVERTEMP_LIMIT = 8'h4F, CMD_OVERTEMP_ACTION = 8'h50, CMD_OVERTEMP_WARNING_LEVEL = 8'h51,
		CMD_INPUT_OVERVOLTAGE_LIMIT = 8'h55, CMD_INPUT_OVERVOLTAGE_ACTION = 8'h56, CMD_OUTPUT_OK_RISE_LEVEL = 8'h5E,
		CMD_OUTPUT_OK_FALL_LEVEL = 8'h5F, CMD_TURN_ON_DELAY_TIME = 8'h60, CMD_TURN_ON_RAMP_TIME = 8'h61,
		CMD_SUMMARY_FLAGS = 8'h79, CMD_OUTPUT_VOLTAGE_FLAGS = 8'h7A, CMD_OUTPUT_CURRENT_FLAGS = 8'h7B,
		CMD_INPUT_FLAGS = 8'h7C, CMD_TEMPERATURE_FLAGS = 8'h7D, CMD_COMMS_LOGIC_FLAGS = 8'h7E,
		CMD_INPUT_VOLTAGE_READING = 8'h88, CMD_OUTPUT_VOLTAGE_READING = 8'h8B, CMD_OUTPUT_CURRENT_READING = 8'h8C,
		CMD_TEMPERATURE_READING = 8'h8D, CMD_PROTOCOL_REVISION = 8'h98, CMD_MODULE_KIND_AND_LOCK = 8'hD0,
		CMD_OUTPUT_READING_GAIN = 8'hD1, CMD_OUTPUT_READING_OFFSET = 8'hD2, CMD_INPUT_READING_GAIN = 8'hD3,
		CMD_INPUT_READING_OFFSET = 8'hD4, CMD_CURRENT_READING_GAIN = 8'hD6, CMD_CURRENT_READING_OFFSET = 8'hD7,
		CMD_FIRMWARE_VERSION = 8'hDB, CMD_PIN_FUNCTION_ALERT_CONFIG = 8'hE0, CMD_SECONDARY_ENABLE_LOGIC = 8'hE1,
		CMD_OUTPUT_OK_PIN_POLARITY = 8'hE2, CMD_BUILD_DATE_SITE_SERIAL = 8'hF0;

	// reset values
	localparam logic [15:0] RST_RUN_CONTROL = 16'h0080, RST_VOUT_FORMAT = 16'h0014, RST_LOAD_DROOP = 16'h0000,
		RST_OV_ACTION = 16'h00B8, RST_OC_ACTION = 16'h00F8, RST_OT_ACTION = 16'h00B8, RST_VIN_OV_ACTION = 16'h00C0,
		RST_OUT_GAIN = 16'h2000, RST_PIN_CFG = 16'h0000, RST_SEC_LOGIC = 16'h0000, RST_OK_POL = 16'h0001;

	// writable masks
	localparam logic [15:0] MASK_SEC_LOGIC = 16'h0003, MASK_OK_POL = 16'h0001, MASK_PIN_CFG = 16'h001F,
		MASK_KIND = 16'hF8FE, MASK_BYTE = 16'h00FF, MASK_WORD = 16'hFFFF, MASK_NONE = 16'h0000;

	// field positions and encodings
	localparam int SEC_COMBINE_BIT     = 1;
	localparam int SEC_POL_BIT         = 0;
	localparam int OK_POL_BIT          = 0;
	localparam int WRITE_PROTECT_BIT   = 1;
	localparam int SUMMARY_COMMS_BIT   = 1;
	localparam int COMMS_BAD_CMD_BIT   = 7;
	localparam int COMMS_BAD_DATA_BIT  = 6;
	localparam logic [3:0] PIN_MAP_SEC_ON_TRIM = 4'h0, PIN_MAP_SEC_ON_SECOND = 4'h2;

	// transfer lengths in data bytes
	localparam logic [3:0] LEN_SEND = 4'h0, LEN_BYTE = 4'h1, LEN_WORD = 4'h2, LEN_BLOCK = 4'(SERIAL_BYTES),
		LEN_NONE = 4'hF;
	localparam logic [7:0] SERIAL_COUNT = 8'(SERIAL_BYTES);
	localparam logic [7:0] FILL_BYTE    = 8'hFF;
	localparam logic [5:0] PIN_IDLE     = 6'h03;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_CMD  = 3'h3,
		ST_WR   = 3'h2,
		ST_RD   = 3'h6
	} pmcb_state_t;
endpackage

// File: rtl/pmcb_top.sv
`timescale 1ns/1ps
module pmcb_top #(
	parameter logic [6:0]  DEV_ADDR          = 7'h10,
	parameter logic [15:0] KIND_DEFAULT      = 16'h00A6, // arbitrary value, write lock set
	parameter logic [15:0] ONOFF_CFG_DEFAULT = 16'h001D,
	parameter logic [15:0] PROTOCOL_REV      = 16'h0012,
	parameter logic [15:0] FW_REV            = 16'h0010
) (
	input  logic                          clk_sys,
	input  logic                          sys_rst,
	input  logic                          scl_in,
	input  logic                          sda_in,
	output logic                          sda_out,
	output logic                          sda_oe,
	input  logic                          primary_request_in,
	input  logic                          trim_multipurpose_pin_in,
	input  logic                          second_multipurpose_pin_in,
	input  logic                          output_good_in,
	input  logic [pmcb_pkg::WORD_W-1:0]   summary_flags_in,
	input  logic [pmcb_pkg::BYTE_W-1:0]   output_voltage_flags_in,
	input  logic [pmcb_pkg::BYTE_W-1:0]   output_current_flags_in,
	input  logic [pmcb_pkg::BYTE_W-1:0]   input_flags_in,
	input  logic [pmcb_pkg::BYTE_W-1:0]   temperature_flags_in,
	input  logic [pmcb_pkg::WORD_W-1:0]   input_voltage_reading_in,
	input  logic [pmcb_pkg::WORD_W-1:0]   output_voltage_reading_in,
	input  logic [pmcb_pkg::WORD_W-1:0]   output_current_reading_in,
	input  logic [pmcb_pkg::WORD_W-1:0]   temperature_reading_in,
	output logic                          output_enable,
	output logic                          output_ok_indication
);
	import pmcb_pkg::*;

	if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77)
	begin : g_bad_addr
		$error("device address lies in a reserved range");
	end

	// ==========================================================
	// command table
	function automatic logic [3:0] cmd_len(input logic [7:0] code);
		case (code)
			CMD_CLEAR_FAULTS, CMD_STORE_DEFAULTS, CMD_RESTORE_DEFAULTS:
				cmd_len = LEN_SEND;
			CMD_RUN_CONTROL, CMD_ENABLE_SOURCE_CONFIG, CMD_OUTPUT_VOLTAGE_FORMAT, CMD_OUTPUT_OVERVOLTAGE_ACTION,
			CMD_OVERCURRENT_ACTION, CMD_OVERTEMP_ACTION, CMD_INPUT_OVERVOLTAGE_ACTION, CMD_OUTPUT_VOLTAGE_FLAGS,
			CMD_OUTPUT_CURRENT_FLAGS, CMD_INPUT_FLAGS, CMD_TEMPERATURE_FLAGS, CMD_COMMS_LOGIC_FLAGS,
			CMD_PROTOCOL_REVISION, CMD_FIRMWARE_VERSION, CMD_PIN_FUNCTION_ALERT_CONFIG, CMD_SECONDARY_ENABLE_LOGIC,
			CMD_OUTPUT_OK_PIN_POLARITY:
				cmd_len = LEN_BYTE;
			CMD_OUTPUT_VOLTAGE_SETPOINT, CMD_OUTPUT_VOLTAGE_TRIM_OFFSET, CMD_MARGIN_HIGH_SETPOINT,
			CMD_MARGIN_LOW_SETPOINT, CMD_LOAD_DROOP_SLOPE, CMD_INPUT_TURN_ON_LEVEL, CMD_INPUT_TURN_OFF_LEVEL,
			CMD_OUTPUT_OVERVOLTAGE_LIMIT, CMD_OVERCURRENT_LIMIT, CMD_OVERCURRENT_WARNING_LEVEL, CMD_OVERTEMP_LIMIT,
			CMD_OVERTEMP_WARNING_LEVEL, CMD_INPUT_OVERVOLTAGE_LIMIT, CMD_OUTPUT_OK_RISE_LEVEL,
			CMD_OUTPUT_OK_FALL_LEVEL, CMD_TURN_ON_DELAY_TIME, CMD_TURN_ON_RAMP_TIME, CMD_SUMMARY_FLAGS,
			CMD_INPUT_VOLTAGE_READING, CMD_OUTPUT_VOLTAGE_READING, CMD_OUTPUT_CURRENT_READING,
			CMD_TEMPERATURE_READING, CMD_MODULE_KIND_AND_LOCK, CMD_OUTPUT_READING_GAIN, CMD_OUTPUT_READING_OFFSET,
			CMD_INPUT_READING_GAIN, CMD_INPUT_READING_OFFSET, CMD_CURRENT_READING_GAIN, CMD_CURRENT_READING_OFFSET:
				cmd_len = LEN_WORD;
			CMD_BUILD_DATE_SITE_SERIAL:
				cmd_len = LEN_BLOCK;
			default:
				cmd_len = LEN_NONE;
		endcase
	endfunction

	function automatic logic [15:0] wmask(input logic [7:0] code);
		case (code)
			CMD_SECONDARY_ENABLE_LOGIC:    wmask = MASK_SEC_LOGIC;
			CMD_OUTPUT_OK_PIN_POLARITY:    wmask = MASK_OK_POL;
			CMD_PIN_FUNCTION_ALERT_CONFIG: wmask = MASK_PIN_CFG;
			CMD_MODULE_KIND_AND_LOCK:      wmask = MASK_KIND;
			CMD_OUTPUT_VOLTAGE_FORMAT, CMD_SUMMARY_FLAGS, CMD_OUTPUT_VOLTAGE_FLAGS, CMD_OUTPUT_CURRENT_FLAGS,
			CMD_INPUT_FLAGS, CMD_TEMPERATURE_FLAGS, CMD_COMMS_LOGIC_FLAGS, CMD_INPUT_VOLTAGE_READING,
			CMD_OUTPUT_VOLTAGE_READING, CMD_OUTPUT_CURRENT_READING, CMD_TEMPERATURE_READING,
			CMD_PROTOCOL_REVISION, CMD_FIRMWARE_VERSION:
				wmask = MASK_NONE;
			default:
				wmask = (cmd_len(code) == LEN_BYTE) ? MASK_BYTE : MASK_WORD;
		endcase
	endfunction

	function automatic logic is_locked(input logic [7:0] code);
		is_locked = (code >= CMD_OUTPUT_READING_GAIN && code <= CMD_CURRENT_READING_OFFSET) ||
			code == CMD_BUILD_DATE_SITE_SERIAL;
	endfunction

	function automatic logic [15:0] reg_default(input logic [7:0] code);
		case (code)
			CMD_RUN_CONTROL:               reg_default = RST_RUN_CONTROL;
			CMD_ENABLE_SOURCE_CONFIG:      reg_default = ONOFF_CFG_DEFAULT;
			CMD_OUTPUT_VOLTAGE_FORMAT:     reg_default = RST_VOUT_FORMAT;
			CMD_LOAD_DROOP_SLOPE:          reg_default = RST_LOAD_DROOP;
			CMD_OUTPUT_OVERVOLTAGE_ACTION: reg_default = RST_OV_ACTION;
			CMD_OVERCURRENT_ACTION:        reg_default = RST_OC_ACTION;
			CMD_OVERTEMP_ACTION:           reg_default = RST_OT_ACTION;
			CMD_INPUT_OVERVOLTAGE_ACTION:  reg_default = RST_VIN_OV_ACTION;
			CMD_PROTOCOL_REVISION:         reg_default = PROTOCOL_REV;
			CMD_MODULE_KIND_AND_LOCK:      reg_default = KIND_DEFAULT;
			CMD_OUTPUT_READING_GAIN:       reg_default = RST_OUT_GAIN;
			CMD_FIRMWARE_VERSION:          reg_default = FW_REV;
			CMD_PIN_FUNCTION_ALERT_CONFIG: reg_default = RST_PIN_CFG;
			CMD_SECONDARY_ENABLE_LOGIC:    reg_default = RST_SEC_LOGIC;
			CMD_OUTPUT_OK_PIN_POLARITY:    reg_default = RST_OK_POL;
			default:                       reg_default = MASK_NONE;
		endcase
	endfunction

	// ==========================================================
	// pin synchronisers and bus events
	logic [PIN_COUNT-1:0] pin_meta_r;
	logic [PIN_COUNT-1:0] pin_sync_r;
	logic [1:0]           line_d_r;
	logic                 scl_s;
	logic                 sda_s;
	logic                 prim_s;
	logic                 trim_s;
	logic                 second_s;
	logic                 good_s;
	logic                 scl_rise;
	logic                 scl_fall;
	logic                 start_ev;
	logic                 stop_ev;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			pin_meta_r <= PIN_IDLE;
			pin_sync_r <= PIN_IDLE;
			line_d_r   <= 2'h3;
		end
		else
		begin
			pin_meta_r <= {output_good_in, second_multipurpose_pin_in, trim_multipurpose_pin_in,
				primary_request_in, sda_in, scl_in};
			pin_sync_r <= pin_meta_r;
			line_d_r   <= pin_sync_r[1:0];
		end
	end

	assign scl_s    = pin_sync_r[0];
	assign sda_s    = pin_sync_r[1];
	assign prim_s   = pin_sync_r[2];
	assign trim_s   = pin_sync_r[3];
	assign second_s = pin_sync_r[4];
	assign good_s   = pin_sync_r[5];
	assign scl_rise = scl_s & ~line_d_r[0];
	assign scl_fall = ~scl_s & line_d_r[0];
	assign start_ev = scl_s & line_d_r[0] & line_d_r[1] & ~sda_s;
	assign stop_ev  = scl_s & line_d_r[0] & ~line_d_r[1] & sda_s;

	// ==========================================================
	// storage
	logic [15:0]  regs_r [0:255];
	logic [7:0]   serial_r [0:SERIAL_BYTES-1];
	logic [7:0]   comms_r;

	// ==========================================================
	// transfer engine
	pmcb_state_t state_r;
	pmcb_state_t next_r;
	pmcb_state_t next_c;
	logic [3:0]  bitcnt_r;
	logic [7:0]  shift_r;
	logic [7:0]  tx_r;
	logic [3:0]  idx_r;
	logic [7:0]  cmd_r;
	logic [7:0]  wbuf_r;
	logic        have_cmd_r;
	logic        mack_r;
	logic        sda_oe_r;
	logic        rx_done;
	logic        ack_c;
	logic        bad_cmd_c;
	logic        bad_data_c;
	logic        wr_ok_c;
	logic        locked_c;
	logic [3:0]  len_c;
	logic [15:0] rd_word_c;
	logic [7:0]  rd_byte_c;
	logic        commit_c;
	logic        ser_we_c;
	logic        clear_c;
	logic        restore_c;

	assign rx_done = scl_fall && bitcnt_r == 4'h9 - 4'h1 && state_r != ST_RD && state_r != ST_IDLE;
	assign len_c   = cmd_len(cmd_r);

	always_comb
	begin
		locked_c = regs_r[CMD_MODULE_KIND_AND_LOCK][WRITE_PROTECT_BIT] && is_locked(cmd_r);
		if (len_c == LEN_BLOCK)
			wr_ok_c = !locked_c && (idx_r == 4'h0 ? shift_r == SERIAL_COUNT : idx_r <= LEN_BLOCK);
		else
			wr_ok_c = !locked_c && idx_r < len_c && wmask(cmd_r) != MASK_NONE;
		ack_c      = 1'b0;
		next_c     = ST_IDLE;
		bad_cmd_c  = 1'b0;
		bad_data_c = 1'b0;
		case (state_r)
			ST_ADDR:
				if (shift_r[7:1] == DEV_ADDR)
				begin
					ack_c      = !shift_r[0] || (have_cmd_r && len_c != LEN_SEND);
					next_c     = !shift_r[0] ? ST_CMD : (ack_c ? ST_RD : ST_IDLE);
					bad_data_c = !ack_c;
				end
			ST_CMD:
			begin
				ack_c     = cmd_len(shift_r) != LEN_NONE;
				next_c    = ack_c ? ST_WR : ST_IDLE;
				bad_cmd_c = !ack_c;
			end
			ST_WR:
			begin
				ack_c      = wr_ok_c;
				next_c     = wr_ok_c ? ST_WR : ST_IDLE;
				bad_data_c = !wr_ok_c;
			end
			default:
				ack_c = 1'b0;
		endcase
		case (cmd_r)
			CMD_SUMMARY_FLAGS:          rd_word_c = summary_flags_in | (16'(|comms_r) << SUMMARY_COMMS_BIT);
			CMD_OUTPUT_VOLTAGE_FLAGS:   rd_word_c = {8'h00, output_voltage_flags_in};
			CMD_OUTPUT_CURRENT_FLAGS:   rd_word_c = {8'h00, output_current_flags_in};
			CMD_INPUT_FLAGS:            rd_word_c = {8'h00, input_flags_in};
			CMD_TEMPERATURE_FLAGS:      rd_word_c = {8'h00, temperature_flags_in};
			CMD_COMMS_LOGIC_FLAGS:      rd_word_c = {8'h00, comms_r};
			CMD_INPUT_VOLTAGE_READING:  rd_word_c = input_voltage_reading_in;
			CMD_OUTPUT_VOLTAGE_READING: rd_word_c = output_voltage_reading_in;
			CMD_OUTPUT_CURRENT_READING: rd_word_c = output_current_reading_in;
			CMD_TEMPERATURE_READING:    rd_word_c = temperature_reading_in;
			default:                    rd_word_c = regs_r[cmd_r];
		endcase
		if (len_c == LEN_BLOCK)
			rd_byte_c = idx_r == 4'h0 ? SERIAL_COUNT : (idx_r <= LEN_BLOCK ? serial_r[4'(idx_r - 4'h1)] : FILL_BYTE);
		else if (idx_r == 4'h0)
			rd_byte_c = rd_word_c[7:0];
		else
			rd_byte_c = (idx_r == LEN_BYTE && len_c == LEN_WORD) ? rd_word_c[15:8] : FILL_BYTE;
	end

	assign commit_c  = rx_done && state_r == ST_WR && wr_ok_c && len_c != LEN_BLOCK && idx_r == len_c - 4'h1;
	assign ser_we_c  = rx_done && state_r == ST_WR && wr_ok_c && len_c == LEN_BLOCK && idx_r != 4'h0;
	assign clear_c   = rx_done && state_r == ST_CMD && shift_r == CMD_CLEAR_FAULTS;
	assign restore_c = rx_done && state_r == ST_CMD && shift_r == CMD_RESTORE_DEFAULTS;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			state_r    <= ST_IDLE;
			next_r     <= ST_IDLE;
			bitcnt_r   <= 4'h0;
			shift_r    <= 8'h00;
			tx_r       <= 8'h00;
			idx_r      <= 4'h0;
			cmd_r      <= 8'h00;
			wbuf_r     <= 8'h00;
			have_cmd_r <= 1'b0;
			mack_r     <= 1'b0;
			sda_oe_r   <= 1'b0;
		end
		else if (stop_ev)
		begin
			state_r    <= ST_IDLE;
			have_cmd_r <= 1'b0;
			sda_oe_r   <= 1'b0;
		end
		else if (start_ev)
		begin
			state_r  <= ST_ADDR;
			bitcnt_r <= 4'h0;
			sda_oe_r <= 1'b0;
		end
		else if (state_r != ST_IDLE && scl_rise)
		begin
			bitcnt_r <= bitcnt_r + 4'h1;
			if (bitcnt_r < 4'h8)
				shift_r <= {shift_r[6:0], sda_s};
			if (bitcnt_r == 4'h8)
				mack_r <= ~sda_s;
		end
		else if (state_r != ST_IDLE && scl_fall)
		begin
			if (state_r == ST_RD && bitcnt_r < 4'h8)
				sda_oe_r <= ~tx_r[3'(4'h7 - bitcnt_r)];
			else if (bitcnt_r == 4'h8)
			begin
				// ack slot: pull low to accept, release to refuse
				sda_oe_r <= (state_r == ST_RD) ? 1'b0 : ack_c;
				next_r   <= (state_r == ST_RD) ? ST_RD : next_c;
				idx_r    <= (state_r == ST_ADDR || state_r == ST_CMD) ? 4'h0 : idx_r + 4'h1;
				if (state_r == ST_CMD)
				begin
					cmd_r      <= shift_r;
					have_cmd_r <= ack_c;
				end
				if (state_r == ST_WR && idx_r == 4'h0)
					wbuf_r <= shift_r;
			end
			else if (bitcnt_r == 4'h9)
			begin
				bitcnt_r <= 4'h0;
				if (state_r == ST_RD ? mack_r : next_r == ST_RD)
				begin
					state_r  <= ST_RD;
					tx_r     <= rd_byte_c;
					sda_oe_r <= ~rd_byte_c[7];
				end
				else
				begin
					state_r  <= (state_r == ST_RD) ? ST_IDLE : next_r;
					sda_oe_r <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// register file and build record
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || restore_c)
		begin
			for (int i = 0; i < 256; i++)
				regs_r[i] <= reg_default(8'(i));
		end
		else if (commit_c)
			regs_r[cmd_r] <= (regs_r[cmd_r] & ~wmask(cmd_r)) |
				(wmask(cmd_r) & (len_c == LEN_WORD ? {shift_r, wbuf_r} : {8'h00, shift_r}));
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < SERIAL_BYTES; i++)
				serial_r[i] <= 8'h00;
		end
		else if (ser_we_c)
			serial_r[4'(idx_r - 4'h1)] <= shift_r;
	end

	// refusal flags: a new refusal wins over a clear in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			comms_r <= 8'h00;
		else
			comms_r <= (clear_c ? 8'h00 : comms_r) |
				(8'(rx_done && bad_cmd_c) << COMMS_BAD_CMD_BIT) | (8'(rx_done && bad_data_c) << COMMS_BAD_DATA_BIT);
	end

	// ==========================================================
	// enable and output-ok logic
	logic [3:0] pin_map;
	logic [7:0] sec_logic;
	logic       sec_present;
	logic       sec_level;
	logic       sec_req;
	logic       en_calc;
	logic       out_enable_r;
	logic       ok_pin_r;

	assign pin_map     = regs_r[CMD_PIN_FUNCTION_ALERT_CONFIG][3:0];
	assign sec_logic   = regs_r[CMD_SECONDARY_ENABLE_LOGIC][7:0];
	assign sec_present = pin_map == PIN_MAP_SEC_ON_TRIM || pin_map == PIN_MAP_SEC_ON_SECOND;
	assign sec_level   = (pin_map == PIN_MAP_SEC_ON_SECOND) ? second_s : trim_s;
	assign sec_req     = sec_logic[SEC_POL_BIT] ? sec_level : ~sec_level;
	assign en_calc     = prim_s & (~sec_logic[SEC_COMBINE_BIT] | ~sec_present | sec_req);

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			out_enable_r <= 1'b0;
			ok_pin_r     <= 1'b0;
		end
		else
		begin
			out_enable_r <= en_calc;
			ok_pin_r     <= regs_r[CMD_OUTPUT_OK_PIN_POLARITY][OK_POL_BIT] ? good_s : ~good_s;
		end
	end

	assign sda_out              = 1'b0;
	assign sda_oe               = sda_oe_r;
	assign output_enable        = out_enable_r;
	assign output_ok_indication = ok_pin_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	sequence s_bad_cmd;
		rx_done && state_r == ST_CMD && cmd_len(shift_r) == LEN_NONE;
	endsequence
	sequence s_extra_word_byte;
		rx_done && state_r == ST_WR && len_c == LEN_WORD && idx_r == LEN_WORD;
	endsequence

	chk_sec_ignored: assert property (!sec_logic[SEC_COMBINE_BIT] && !restore_c && !commit_c |=>
		output_enable == $past(prim_s)) else $error("secondary input affected enable");
	chk_and_combine: assert property (sec_logic[SEC_COMBINE_BIT] && sec_present && !sec_req |=>
		!output_enable) else $error("enable without secondary request");
	chk_neg_polarity: assert property (sec_logic[1:0] == 2'h2 && sec_present && prim_s && !sec_level |=>
		output_enable) else $error("low level did not enable");
	chk_pos_polarity: assert property (sec_logic[1:0] == 2'h3 && sec_present && prim_s && !sec_level |=>
		!output_enable) else $error("low level enabled in positive mode");
	chk_logic_reserved: assert property (regs_r[CMD_SECONDARY_ENABLE_LOGIC][15:2] == 14'h0000)
		else $error("secondary logic reserved bits set");
	chk_pg_negative: assert property (!regs_r[CMD_OUTPUT_OK_PIN_POLARITY][OK_POL_BIT] && good_s && !commit_c
		|=> !output_ok_indication) else $error("output-ok pin not low in negative mode");
	chk_pg_positive: assert property (regs_r[CMD_OUTPUT_OK_PIN_POLARITY][OK_POL_BIT] && !commit_c && !restore_c
		|=> output_ok_indication == $past(good_s)) else $error("output-ok pin wrong in positive mode");
	chk_pol_reserved: assert property (regs_r[CMD_OUTPUT_OK_PIN_POLARITY][15:1] == 15'h0000)
		else $error("polarity reserved bits set");
	chk_serial_lock: assert property (rx_done && state_r == ST_WR && cmd_r == CMD_BUILD_DATE_SITE_SERIAL &&
		regs_r[CMD_MODULE_KIND_AND_LOCK][WRITE_PROTECT_BIT] |=> !sda_oe ##1 !sda_oe)
		else $error("locked record write acked");
	chk_bad_cmd: assert property (s_bad_cmd |=> comms_r[COMMS_BAD_CMD_BIT] && !sda_oe)
		else $error("unknown command accepted");
	chk_extra_byte: assert property (s_extra_word_byte |=> !sda_oe && comms_r[COMMS_BAD_DATA_BIT])
		else $error("third byte of word accepted");
	chk_cal_lock: assert property (rx_done && state_r == ST_WR && locked_c && cmd_r != CMD_BUILD_DATE_SITE_SERIAL
		|=> regs_r[$past(cmd_r)] == $past(regs_r[cmd_r])) else $error("locked calibration changed");
	chk_pin_route: assert property (pin_map == PIN_MAP_SEC_ON_SECOND && sec_logic[1:0] == 2'h3 && prim_s &&
		second_s && !trim_s |=> output_enable) else $error("secondary not taken from second pin");
	chk_enable_track: assert property (##1 output_enable == $past(en_calc))
		else $error("enable not tracking its inputs");
endmodule

// File: test/pmcb_host.sv
`timescale 1ns/1ps
module pmcb_host (
	input  wire logic clk_sys,
	input  wire logic sda,
	output logic      scl     = 1'b1,
	output logic      sda_rel = 1'b1
);
	// ==========================================
	// bus master: 8 clk per bus clock, data moves mid-low
	task automatic step(input logic c, input logic d, input int n);
		scl = c;
		sda_rel = d;
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic start;
		step(scl, 1'b1, 2);
		step(1'b1, 1'b1, 4);
		step(1'b1, 1'b0, 4);
		step(1'b0, 1'b0, 2);
	endtask
	task automatic stop;
		step(1'b0, 1'b0, 2);
		step(1'b1, 1'b0, 4);
		step(1'b1, 1'b1, 4);
	endtask
	// eight bits then the acknowledge bit, m is what the master puts there
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic ok);
		logic [8:0] v = {d, m};
		for (int i = 8; i >= 0; i--)
		begin
			step(1'b0, v[i], 2);
			step(1'b1, v[i], 4);
			v[i] = sda;
			step(1'b0, sda_rel, 2);
		end
		q = v[8:1];
		ok = ~v[0];
	endtask
	task automatic head(input logic [7:0] c, output logic ok);
		logic [7:0] q;
		logic       a;
		start();
		xfer(8'h20, 1'b1, q, ok);
		xfer(c, 1'b1, q, a);
		ok = ok & a;
	endtask
	task automatic wr(input logic [7:0] c, input int n, input logic [103:0] d, output logic ok);
		logic [7:0] q;
		logic       a;
		head(c, ok);
		for (int i = 0; i < n; i++)
		begin
			xfer(d[8*i+:8], 1'b1, q, a);
			ok = ok & a;
		end
		stop();
	endtask
	task automatic rd(input logic [7:0] c, input int n, output logic [103:0] d, output logic ok);
		logic a;
		d = '0;
		head(c, ok);
		start();
		xfer(8'h21, 1'b1, d[7:0], a);
		ok = ok & a;
		for (int i = 0; i < n; i++)
			xfer(8'hFF, i == n - 1, d[8*i+:8], a);
		stop();
	endtask
endmodule

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import pmcb_pkg::*;
	logic         clk_sys = 1'b0, sys_rst = 1'b1, prim = 1'b0, trim = 1'b0, sec = 1'b0, good = 1'b0;
	logic         scl, rel, sda_oe, en, okp, ok;
	logic [103:0] d;
	logic [15:0]  w = 16'h5A3C;
	logic [7:0]   b = 8'hA5;
	int           failures = 0, compares = 0, cyc = 0;
	always #50 clk_sys = ~clk_sys;
	pmcb_host host (.clk_sys(clk_sys), .sda(rel & ~sda_oe), .scl(scl), .sda_rel(rel));
	pmcb_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl), .sda_in(rel & ~sda_oe), .sda_out(),
		.sda_oe(sda_oe), .primary_request_in(prim), .trim_multipurpose_pin_in(trim),
		.second_multipurpose_pin_in(sec), .output_good_in(good), .summary_flags_in(w),
		.output_voltage_flags_in(b), .output_current_flags_in(b), .input_flags_in(b), .temperature_flags_in(b),
		.input_voltage_reading_in(w), .output_voltage_reading_in(w), .output_current_reading_in(w),
		.temperature_reading_in(w), .output_enable(en), .output_ok_indication(okp));
	// ==========================================
	// checking and closing
	task chk(input string s, input logic [103:0] e, input logic [103:0] g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	task wrd(input string s, input logic [7:0] c, input int n, input logic [103:0] v, input logic [103:0] e);
		host.wr(c, n, v, ok);
		host.rd(c, n, d, ok);
		chk(s, e, d);
	endtask
	task give_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			failures++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (6) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		host.rd(CMD_SECONDARY_ENABLE_LOGIC, 1, d, ok);
		chk("sec logic default", 8'h00, d);
		host.rd(CMD_OUTPUT_OK_PIN_POLARITY, 1, d, ok);
		chk("ok polarity default", 8'h01, d);
		wrd("sec logic", CMD_SECONDARY_ENABLE_LOGIC, 1, 8'hFF, 8'h03);
		wrd("ok polarity", CMD_OUTPUT_OK_PIN_POLARITY, 1, 8'hFE, 8'h00);
		$display("test masks done");
		host.wr(CMD_PIN_FUNCTION_ALERT_CONFIG, 1, 8'h02, ok);
		for (int k = 0; k < 16; k++)
		begin
			host.wr(CMD_SECONDARY_ENABLE_LOGIC, 1, 104'(k >> 2), ok);
			prim = k[1];
			sec = k[0];
			trim = ~k[0];
			repeat (5) @(negedge clk_sys);
			chk("enable", 1'(k[1] & (~k[3] | (k[2] ~^ k[0]))), en);
		end
		host.wr(CMD_PIN_FUNCTION_ALERT_CONFIG, 1, 8'h00, ok);
		repeat (5) @(negedge clk_sys);
		chk("enable on trim pin", 1'b0, en);
		for (int k = 0; k < 4; k++)
		begin
			host.wr(CMD_OUTPUT_OK_PIN_POLARITY, 1, 104'(k[1]), ok);
			good = k[0];
			repeat (5) @(negedge clk_sys);
			chk("ok pin", 1'(k[1] ~^ k[0]), okp);
		end
		$display("test pins done");
		host.wr(CMD_BUILD_DATE_SITE_SERIAL, 13, {96'h0123456789ABCDEF00112233, 8'h0C}, ok);
		chk("locked write ack", 1'b0, ok);
		host.wr(CMD_OUTPUT_READING_GAIN, 2, 16'h1111, ok);
		chk("locked gain ack", 1'b0, ok);
		host.rd(CMD_OUTPUT_READING_GAIN, 2, d, ok);
		chk("locked gain kept", 16'h2000, d);
		host.rd(CMD_COMMS_LOGIC_FLAGS, 1, d, ok);
		chk("bad data flag", 8'h40, d);
		host.wr(CMD_CLEAR_FAULTS, 0, 0, ok);
		chk("send byte ack", 1'b1, ok);
		wrd("unlock", CMD_MODULE_KIND_AND_LOCK, 2, 16'h00A4, 16'h00A4);
		wrd("block", CMD_BUILD_DATE_SITE_SERIAL, 13, {96'h0123456789ABCDEF00112233, 8'h0C},
			{96'h0123456789ABCDEF00112233, 8'h0C});
		$display("test protect done");
		wrd("word", CMD_OUTPUT_VOLTAGE_SETPOINT, 2, 16'h1234, 16'h1234);
		host.wr(8'h05, 0, 0, ok);
		host.rd(CMD_COMMS_LOGIC_FLAGS, 1, d, ok);
		chk("bad command flag", 8'h80, d);
		host.wr(CMD_OUTPUT_VOLTAGE_FORMAT, 1, 8'h55, ok);
		chk("read-only write ack", 1'b0, ok);
		host.wr(CMD_OUTPUT_VOLTAGE_SETPOINT, 3, 24'h775678, ok);
		chk("extra byte ack", 1'b0, ok);
		host.rd(CMD_OUTPUT_VOLTAGE_SETPOINT, 2, d, ok);
		chk("word kept", 16'h5678, d);
		host.rd(CMD_INPUT_VOLTAGE_READING, 2, d, ok);
		chk("reading", w, d);
		host.rd(CMD_SUMMARY_FLAGS, 2, d, ok);
		chk("summary flags", 16'h5A3E, d);
		host.wr(CMD_RESTORE_DEFAULTS, 0, 0, ok);
		host.rd(CMD_SECONDARY_ENABLE_LOGIC, 1, d, ok);
		chk("restore", 8'h00, d);
		$display("test transfers done");
		give_verdict();
	end
endmodule
